//--- src/aparc_top.sv
// Notes on behaviour
// - First dac always on P0.0; second dac on P0.0 or P0.1 by merge bit.
// - With both dac enables 0 the pins stay ordinary gpio.
// - An enabled dac pin loses its driver and pull-up, joins the dac.
// - Both dacs enabled and merge 1: both outputs land on P0.0.
// - Reference select 0 picks pin or internal source, 1 picks supply.
// - Buffer enable 1 drives internal reference out; clear it when unused.
// - Bias forced on while converter, sensor, oscillators or dacs run.
// - Writing 1 to bias enable turns bias on by itself.
// - Sensor enable switches sensor; off means high impedance, invalid data.
// - Reference level bit picks 1.5 V or 2.2 V internal output.
// - Merge 0 sends second dac to P0.1, merge 1 to P0.0.
`timescale 1ns/1ps
`default_nettype none
module aparc_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [aparc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [aparc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [aparc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic adc_enable,
    input wire logic osc_enable,
    input wire logic [1:0] gpio_out,
    input wire logic [1:0] gpio_oe_n,
    input wire logic [1:0] gpio_pullup,
    output logic [1:0] pad_out,
    output logic [1:0] pad_oe_n,
    output logic [1:0] pad_pullup,
    output logic dac0_to_p00,
    output logic dac1_to_p00,
    output logic dac1_to_p01,
    output logic [1:0] dac_enable,
    output logic ref_src_vdd,
    output logic ref_buf_en,
    output logic ref_level_hi,
    output logic bias_gen_en,
    output logic temp_sensor_en,
    output logic temp_out_hiz,
    output logic ztc_bias_en
);
    import aparc_pkg::*;
    logic [7:0] ref_ctrl_ff;
    logic [7:0] nxt_ref_ctrl;
    logic [1:0] dac_en_ff;
    logic [1:0] nxt_dac_en;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic ref_vdd_ff;
    logic ref_buf_ff;
    logic ref_lvl_ff;
    logic bias_ff;
    logic nxt_bias;
    logic temp_en_ff;
    logic temp_hiz_ff;
    logic ztc_ff;
    logic [CNT_W-1:0] startup_cnt_ff;
    logic dac_ready_ff;
    logic [7:0] status_word;

    aparc_route_if rif ();

    function automatic logic addr_hit(input logic [3:0] a,
                                      input logic [3:0] target);
        addr_hit = (a == target);
    endfunction : addr_hit

    // next register values, so outputs move on the same edge as the
    // register itself
    always_comb begin
        nxt_ref_ctrl = ref_ctrl_ff;
        nxt_dac_en = dac_en_ff;
        if (reg_wr && addr_hit(reg_addr, REF_CTRL_ADDR)) begin
            nxt_ref_ctrl = reg_wdata;
        end
        if (reg_wr && addr_hit(reg_addr, DAC_EN_ADDR)) begin
            nxt_dac_en = reg_wdata[1:0];
        end
    end

    // bias is the written bit or any user of the bias generator
    always_comb begin
        nxt_bias = nxt_ref_ctrl[BIAS_EN_BIT]
            | adc_enable | osc_enable
            | nxt_ref_ctrl[TEMP_EN_BIT] | (|nxt_dac_en);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ref_ctrl_ff <= REF_CTRL_RST;
        end else begin
            ref_ctrl_ff <= nxt_ref_ctrl;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dac_en_ff <= DAC_EN_RST;
        end else begin
            dac_en_ff <= nxt_dac_en;
        end
    end

    // reference, sensor and bias outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ref_vdd_ff <= REF_CTRL_RST[SRC_SEL_BIT];
            ref_buf_ff <= REF_CTRL_RST[BUF_EN_BIT];
            ref_lvl_ff <= REF_CTRL_RST[LEVEL_SEL_BIT];
            temp_en_ff <= REF_CTRL_RST[TEMP_EN_BIT];
            temp_hiz_ff <= ~REF_CTRL_RST[TEMP_EN_BIT];
            ztc_ff <= REF_CTRL_RST[ZTC_BIT];
            bias_ff <= REF_CTRL_RST[BIAS_EN_BIT];
        end else begin
            ref_vdd_ff <= nxt_ref_ctrl[SRC_SEL_BIT];
            ref_buf_ff <= nxt_ref_ctrl[BUF_EN_BIT];
            ref_lvl_ff <= nxt_ref_ctrl[LEVEL_SEL_BIT];
            temp_en_ff <= nxt_ref_ctrl[TEMP_EN_BIT];
            temp_hiz_ff <= ~nxt_ref_ctrl[TEMP_EN_BIT];
            ztc_ff <= nxt_ref_ctrl[ZTC_BIT];
            bias_ff <= nxt_bias;
        end
    end

    // dac outputs need time to settle; software polls the ready bit
    always_ff @(posedge core_clk) begin
        if (rst || dac_en_ff == 2'h0) begin
            startup_cnt_ff <= '0;
            dac_ready_ff <= 1'b0;
        end else if (!dac_ready_ff) begin
            if (startup_cnt_ff == STARTUP_LAST) begin
                dac_ready_ff <= 1'b1;
            end else begin
                startup_cnt_ff <= startup_cnt_ff + 9'h001;
            end
        end
    end

    always_comb begin
        status_word = 8'h00;
        status_word[ST_BIAS_BIT] = bias_ff;
        status_word[ST_TEMP_VALID_BIT] = temp_en_ff;
        status_word[ST_P00_ANALOG_BIT] = rif.analog[PIN_P00];
        status_word[ST_P01_ANALOG_BIT] = rif.analog[PIN_P01];
        status_word[ST_DAC_READY_BIT] = dac_ready_ff;
        status_word[ST_MERGED_BIT] = dac1_to_p00;
    end

    // read data stand for one cycle only, zero otherwise
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                REF_CTRL_ADDR: begin
                    nxt_rdata = ref_ctrl_ff;
                    // forced bias shows in the readback
                    nxt_rdata[BIAS_EN_BIT] = bias_ff;
                end
                DAC_EN_ADDR: nxt_rdata = {6'h00, dac_en_ff};
                STATUS_ADDR: nxt_rdata = status_word;
                default: nxt_rdata = UNMAPPED_DATA;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rif.dac_en = nxt_dac_en;
    assign rif.merge = nxt_ref_ctrl[MRG_BIT];

    aparc_pin_route u_pin_route (
        .core_clk(core_clk),
        .rst(rst),
        .rif(rif.route),
        .gpio_out(gpio_out),
        .gpio_oe_n(gpio_oe_n),
        .gpio_pullup(gpio_pullup),
        .pad_out(pad_out),
        .pad_oe_n(pad_oe_n),
        .pad_pullup(pad_pullup),
        .dac0_to_p00(dac0_to_p00),
        .dac1_to_p00(dac1_to_p00),
        .dac1_to_p01(dac1_to_p01)
    );

    assign reg_rdata = rdata_ff;
    assign dac_enable = dac_en_ff;
    assign ref_src_vdd = ref_vdd_ff;
    assign ref_buf_en = ref_buf_ff;
    assign ref_level_hi = ref_lvl_ff;
    assign bias_gen_en = bias_ff;
    assign temp_sensor_en = temp_en_ff;
    assign temp_out_hiz = temp_hiz_ff;
    assign ztc_bias_en = ztc_ff;

    // the second dac may sit on one pin only, never on both at once
    property p_dac1_one_pin;
        @(posedge core_clk) disable iff (rst)
        !(dac1_to_p00 && dac1_to_p01);
    endproperty
    a_dac1_one_pin: assert property (p_dac1_one_pin)
        else $error("second dac switched onto both pins");

    property p_dac0_follows_en;
        @(posedge core_clk) disable iff (rst)
        dac0_to_p00 == dac_en_ff[DAC0_EN_BIT];
    endproperty
    a_dac0_follows_en: assert property (p_dac0_follows_en)
        else $error("first dac switch disagrees with its enable");

    property p_gpio_pass;
        @(posedge core_clk) disable iff (rst)
        dac_en_ff == 2'h0 && !$past(rst) |->
            pad_oe_n == $past(gpio_oe_n) && pad_out == $past(gpio_out)
            && pad_pullup == $past(gpio_pullup);
    endproperty
    a_gpio_pass: assert property (p_gpio_pass)
        else $error("pins not plain gpio with dacs off");

    property p_dac1_pin_released;
        @(posedge core_clk) disable iff (rst)
        dac_en_ff[DAC1_EN_BIT] && !ref_ctrl_ff[MRG_BIT] |->
            pad_oe_n[PIN_P01] && !pad_pullup[PIN_P01] && dac1_to_p01;
    endproperty
    a_dac1_pin_released: assert property (p_dac1_pin_released)
        else $error("second dac pin still driven or pulled up");

    property p_dac0_pin_released;
        @(posedge core_clk) disable iff (rst)
        dac_en_ff[DAC0_EN_BIT] |->
            pad_oe_n[PIN_P00] && !pad_pullup[PIN_P00];
    endproperty
    a_dac0_pin_released: assert property (p_dac0_pin_released)
        else $error("first dac pin still driven or pulled up");

    property p_merge;
        @(posedge core_clk) disable iff (rst)
        dac_en_ff == 2'h3 && ref_ctrl_ff[MRG_BIT] |->
            dac0_to_p00 && dac1_to_p00 && !dac1_to_p01
            && pad_oe_n[PIN_P00];
    endproperty
    a_merge: assert property (p_merge)
        else $error("dac outputs not merged on p0.0");

    property p_unmerged;
        @(posedge core_clk) disable iff (rst)
        !ref_ctrl_ff[MRG_BIT] |-> !dac1_to_p00;
    endproperty
    a_unmerged: assert property (p_unmerged)
        else $error("second dac on p0.0 while merge is clear");

    property p_ref_select;
        @(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == REF_CTRL_ADDR |=>
            ref_src_vdd == $past(reg_wdata[SRC_SEL_BIT])
            && ref_buf_en == $past(reg_wdata[BUF_EN_BIT]);
    endproperty
    a_ref_select: assert property (p_ref_select)
        else $error("reference select or buffer missed a write");

    property p_level;
        @(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == REF_CTRL_ADDR |=>
            ref_level_hi == $past(reg_wdata[LEVEL_SEL_BIT]);
    endproperty
    a_level: assert property (p_level)
        else $error("reference level did not follow write");

    property p_bias_forced;
        @(posedge core_clk) disable iff (rst)
        adc_enable || osc_enable || temp_sensor_en || dac_enable != 2'h0
            |-> ##[0:1] bias_gen_en;
    endproperty
    a_bias_forced: assert property (p_bias_forced)
        else $error("bias off while a user is enabled");

    property p_bias_manual;
        @(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == REF_CTRL_ADDR && reg_wdata[BIAS_EN_BIT] |=>
            bias_gen_en;
    endproperty
    a_bias_manual: assert property (p_bias_manual)
        else $error("bias not on after writing its enable");

    property p_bias_idle;
        @(posedge core_clk) disable iff (rst)
        !$past(adc_enable) && !$past(osc_enable) && !temp_sensor_en
            && dac_enable == 2'h0 && !ref_ctrl_ff[BIAS_EN_BIT] |->
            !bias_gen_en;
    endproperty
    a_bias_idle: assert property (p_bias_idle)
        else $error("bias on with no cause");

    property p_temp_hiz;
        @(posedge core_clk) disable iff (rst)
        temp_out_hiz == !temp_sensor_en;
    endproperty
    a_temp_hiz: assert property (p_temp_hiz)
        else $error("sensor output not high impedance while off");

    property p_dac_write_next;
        @(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == DAC_EN_ADDR |=>
            dac0_to_p00 == $past(reg_wdata[0])
            && pad_oe_n[PIN_P00] == ($past(reg_wdata[0]) ||
            (ref_ctrl_ff[MRG_BIT] && $past(reg_wdata[1])) ||
            $past(gpio_oe_n[PIN_P00]));
    endproperty
    a_dac_write_next: assert property (p_dac_write_next)
        else $error("pin override late after enable write");

    property p_ready_time;
        @(posedge core_clk) disable iff (rst)
        $rose(dac_ready_ff) |->
            startup_cnt_ff == STARTUP_LAST && $past(dac_en_ff) != 2'h0;
    endproperty
    a_ready_time: assert property (p_ready_time)
        else $error("dac ready before its startup time");

    property p_read_window;
        @(posedge core_clk) disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_read_window: assert property (p_read_window)
        else $error("read data present outside the read slot");
endmodule : aparc_top
`default_nettype wire

//--- src/aparc_pkg.sv
package aparc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets on the plain register port
    localparam logic [3:0] REF_CTRL_ADDR = 4'h0;
    localparam logic [3:0] DAC_EN_ADDR = 4'h1;
    localparam logic [3:0] STATUS_ADDR = 4'h2;

    localparam logic [7:0] REF_CTRL_RST = 8'h00;
    localparam logic [1:0] DAC_EN_RST = 2'h0;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // reference_control_register fields
    localparam int MRG_BIT = 7;
    localparam int GF_BIT = 6;
    localparam int ZTC_BIT = 5;
    localparam int LEVEL_SEL_BIT = 4;
    localparam int SRC_SEL_BIT = 3;
    localparam int TEMP_EN_BIT = 2;
    localparam int BIAS_EN_BIT = 1;
    localparam int BUF_EN_BIT = 0;

    // current_dac_enable register fields
    localparam int DAC0_EN_BIT = 0;
    localparam int DAC1_EN_BIT = 1;

    // status register fields
    localparam int ST_BIAS_BIT = 0;
    localparam int ST_TEMP_VALID_BIT = 1;
    localparam int ST_P00_ANALOG_BIT = 2;
    localparam int ST_P01_ANALOG_BIT = 3;
    localparam int ST_DAC_READY_BIT = 4;
    localparam int ST_MERGED_BIT = 5;

    // port 0 pin indices
    localparam int PIN_P00 = 0;
    localparam int PIN_P01 = 1;

    // pad state after reset: not driven, weak pull-up on
    localparam logic [1:0] PAD_OE_N_RST = 2'h3;
    localparam logic [1:0] PAD_PULL_RST = 2'h3;
    localparam logic [1:0] PAD_OUT_RST = 2'h0;

    // current dac output startup
    localparam int CLK_PERIOD_NS = 25;
    localparam int DAC_STARTUP_NS = 10000;
    localparam int DAC_STARTUP_CYC =
        (DAC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 9;
    localparam logic [8:0] STARTUP_LAST = 9'(DAC_STARTUP_CYC - 1);
endpackage : aparc_pkg

//--- src/aparc_route_if.sv
`timescale 1ns/1ps
`default_nettype none
interface aparc_route_if;
    logic [1:0] dac_en;
    logic merge;
    logic [1:0] analog;
    modport ctrl (output dac_en, output merge, input analog);
    modport route (input dac_en, input merge, output analog);
endinterface : aparc_route_if
`default_nettype wire

//--- src/aparc_pin_route.sv
`timescale 1ns/1ps
`default_nettype none
module aparc_pin_route (
    input wire logic core_clk,
    input wire logic rst,
    aparc_route_if.route rif,
    input wire logic [1:0] gpio_out,
    input wire logic [1:0] gpio_oe_n,
    input wire logic [1:0] gpio_pullup,
    output logic [1:0] pad_out,
    output logic [1:0] pad_oe_n,
    output logic [1:0] pad_pullup,
    output logic dac0_to_p00,
    output logic dac1_to_p00,
    output logic dac1_to_p01
);
    import aparc_pkg::*;
    logic [1:0] analog_ff;
    logic [1:0] nxt_analog;
    logic [1:0] out_ff;
    logic [1:0] oe_n_ff;
    logic [1:0] pull_ff;
    logic [2:0] sw_ff;

    // a pin turns analog when a dac that is enabled is routed onto it
    function automatic logic pin_analog(input int pin,
                                        input logic [1:0] en,
                                        input logic mrg);
        if (pin == PIN_P00) begin
            pin_analog = en[DAC0_EN_BIT] | (en[DAC1_EN_BIT] & mrg);
        end else begin
            pin_analog = en[DAC1_EN_BIT] & ~mrg;
        end
    endfunction : pin_analog

    always_comb begin
        nxt_analog[PIN_P00] = pin_analog(PIN_P00, rif.dac_en, rif.merge);
        nxt_analog[PIN_P01] = pin_analog(PIN_P01, rif.dac_en, rif.merge);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            analog_ff <= 2'h0;
        end else begin
            analog_ff <= nxt_analog;
        end
    end

    // pad drivers: gpio passes through unless the pin went analog
    always_ff @(posedge core_clk) begin
        if (rst) begin
            out_ff <= PAD_OUT_RST;
            oe_n_ff <= PAD_OE_N_RST;
            pull_ff <= PAD_PULL_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (nxt_analog[i]) begin
                    out_ff[i] <= 1'b0;
                    oe_n_ff[i] <= 1'b1;
                    pull_ff[i] <= 1'b0;
                end else begin
                    out_ff[i] <= gpio_out[i];
                    oe_n_ff[i] <= gpio_oe_n[i];
                    pull_ff[i] <= gpio_pullup[i];
                end
            end
        end
    end

    // analog switches; both dacs on p0.0 when merged
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sw_ff <= 3'h0;
        end else begin
            sw_ff[0] <= rif.dac_en[DAC0_EN_BIT];
            sw_ff[1] <= rif.dac_en[DAC1_EN_BIT] & rif.merge;
            sw_ff[2] <= rif.dac_en[DAC1_EN_BIT] & ~rif.merge;
        end
    end

    assign rif.analog = analog_ff;
    assign pad_out = out_ff;
    assign pad_oe_n = oe_n_ff;
    assign pad_pullup = pull_ff;
    assign dac0_to_p00 = sw_ff[0];
    assign dac1_to_p00 = sw_ff[1];
    assign dac1_to_p01 = sw_ff[2];
endmodule : aparc_pin_route
`default_nettype wire

//--- sim/aparc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module aparc_top_tb_top;
    import aparc_pkg::*;
    logic core_clk;
    logic rst;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic adc_enable;
    logic osc_enable;
    logic [1:0] gpio_out;
    logic [1:0] gpio_oe_n;
    logic [1:0] gpio_pullup;
    logic [1:0] pad_out;
    logic [1:0] pad_oe_n;
    logic [1:0] pad_pullup;
    logic dac0_to_p00;
    logic dac1_to_p00;
    logic dac1_to_p01;
    logic [1:0] dac_enable;
    logic ref_src_vdd;
    logic ref_buf_en;
    logic ref_level_hi;
    logic bias_gen_en;
    logic temp_sensor_en;
    logic temp_out_hiz;
    logic ztc_bias_en;
    int n_mismatch;
    int n_checks;

    aparc_top i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .adc_enable(adc_enable),
        .osc_enable(osc_enable), .gpio_out(gpio_out),
        .gpio_oe_n(gpio_oe_n), .gpio_pullup(gpio_pullup),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup),
        .dac0_to_p00(dac0_to_p00), .dac1_to_p00(dac1_to_p00),
        .dac1_to_p01(dac1_to_p01), .dac_enable(dac_enable),
        .ref_src_vdd(ref_src_vdd), .ref_buf_en(ref_buf_en),
        .ref_level_hi(ref_level_hi), .bias_gen_en(bias_gen_en),
        .temp_sensor_en(temp_sensor_en), .temp_out_hiz(temp_out_hiz),
        .ztc_bias_en(ztc_bias_en));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // reset is taken again in mid-run with every control bit set
    task automatic t_reset(input int cycles);
        logic [7:0] d;
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (cycles) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        chk({3'h0, dac0_to_p00, dac1_to_p00, dac1_to_p01, dac_enable}, 8'h00,
            "sw");
        chk({2'h0, pad_oe_n, pad_pullup, pad_out}, 8'h3C, "pads rst");
        chk({4'h0, ref_src_vdd, ref_buf_en, ref_level_hi, bias_gen_en}, 8'h00,
            "ref rst");
        chk({5'h0, temp_sensor_en, temp_out_hiz, ztc_bias_en}, 8'h02,
            "temp rst");
        chk(reg_rdata, 8'h00, "rdata rst");
        rd(REF_CTRL_ADDR, d);
        chk(d, REF_CTRL_RST, "ref ctrl rst");
        rd(DAC_EN_ADDR, d);
        chk(d, {6'h00, DAC_EN_RST}, "dac en rst");
    endtask : t_reset

    task automatic t_gpio;
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            gpio_out <= i ? 2'h1 : 2'h2;
            gpio_oe_n <= i ? 2'h2 : 2'h1;
            gpio_pullup <= i ? 2'h0 : 2'h3;
            @(posedge core_clk);
            #1;
            chk({6'h00, pad_out}, {6'h00, gpio_out}, "pad out");
            chk({6'h00, pad_oe_n}, {6'h00, gpio_oe_n}, "pad oe");
            chk({6'h00, pad_pullup}, {6'h00, gpio_pullup}, "pull");
        end
    endtask : t_gpio

    // gpio asks for drive high with pull-up so an analog pin differs
    task automatic t_route;
        logic [1:0] e;
        logic m;
        logic a0;
        logic a1;
        logic [7:0] d;
        logic [7:0] st;
        // the dac pins are skipped in the crossbar: only the port latch
        // reaches them, which is what gpio_* stand for here
        @(posedge core_clk);
        gpio_out <= 2'h3;
        gpio_oe_n <= 2'h0;
        gpio_pullup <= 2'h3;
        for (int k = 0; k < 8; k++) begin
            m = k[2];
            e = k[1:0];
            a0 = e[0] | (e[1] & m);
            a1 = e[1] & ~m;
            wr(REF_CTRL_ADDR, {m, 7'h00});
            wr(DAC_EN_ADDR, {6'h3F, e});
            chk({6'h00, dac_enable}, {6'h00, e}, "dac en");
            chk({7'h00, dac0_to_p00}, {7'h00, e[0]}, "dac0 p00");
            chk({7'h00, dac1_to_p00}, {7'h00, e[1] & m}, "dac1 p00");
            chk({7'h00, dac1_to_p01}, {7'h00, e[1] & ~m}, "dac1 p01");
            chk({6'h00, pad_oe_n}, {6'h00, a1, a0}, "oe");
            chk({6'h00, pad_pullup}, {6'h00, ~a1, ~a0}, "pull");
            chk({6'h00, pad_out}, {6'h00, ~a1, ~a0}, "out");
            chk({7'h00, bias_gen_en}, {7'h00, |e}, "bias dac");
            // too few cycles per step for the dac ready bit to rise
            st = {2'h0, e[1] & m, 1'b0, a1, a0, 1'b0, |e};
            rd(STATUS_ADDR, d);
            chk(d & 8'h3F, st, "status pins");
        end
        wr(DAC_EN_ADDR, 8'h00);
    endtask : t_route

    task automatic t_ref;
        logic [7:0] w;
        logic [7:0] d;
        logic b;
        for (int i = 0; i < 9; i++) begin
            w = (i < 8) ? (8'h01 << i) : 8'h00;
            b = w[BIAS_EN_BIT] | w[TEMP_EN_BIT];
            // the reference pin counts as analog and skipped by software
            wr(REF_CTRL_ADDR, w);
            chk({7'h00, ref_src_vdd}, {7'h00, w[3]}, "ref src");
            chk({7'h00, ref_buf_en}, {7'h00, w[0]}, "ref buf");
            chk({7'h00, ref_level_hi}, {7'h00, w[4]}, "ref lvl");
            chk({7'h00, temp_sensor_en}, {7'h00, w[2]}, "temp");
            chk({7'h00, temp_out_hiz}, {7'h00, ~w[2]}, "hiz");
            chk({7'h00, ztc_bias_en}, {7'h00, w[5]}, "ztc");
            chk({7'h00, bias_gen_en}, {7'h00, b}, "bias");
            rd(REF_CTRL_ADDR, d);
            chk(d, w | {6'h00, b, 1'b0}, "ref readback");
        end
    endtask : t_ref

    task automatic t_bias;
        logic [7:0] d;
        wr(REF_CTRL_ADDR, 8'h00);
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            if (k == 0) adc_enable <= 1'b1;
            else osc_enable <= 1'b1;
            @(posedge core_clk);
            #1;
            chk({7'h00, bias_gen_en}, 8'h01, "bias forced");
            @(posedge core_clk);
            adc_enable <= 1'b0;
            osc_enable <= 1'b0;
            @(posedge core_clk);
            #1;
            chk({7'h00, bias_gen_en}, 8'h00, "bias released");
        end
        rd(REF_CTRL_ADDR, d);
        chk(d, 8'h00, "stored bias kept 0");
    endtask : t_bias

    // back-to-back reads, unmapped places, dac startup status
    task automatic t_bus;
        logic [7:0] d;
        wr(REF_CTRL_ADDR, 8'h5A);
        wr(4'h9, 8'hFF);
        wr(STATUS_ADDR, 8'hFF);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= REF_CTRL_ADDR;
        @(posedge core_clk);
        reg_addr <= 4'hF;
        #1;
        chk(reg_rdata, 8'h5A, "b2b first");
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, UNMAPPED_DATA, "unmapped read");
        @(posedge core_clk);
        #1;
        chk(reg_rdata, 8'h00, "rdata one cycle");
        wr(DAC_EN_ADDR, 8'h01);
        rd(STATUS_ADDR, d);
        chk(d & 8'h10, 8'h00, "dac not ready");
        repeat (DAC_STARTUP_CYC + 10) @(posedge core_clk);
        rd(STATUS_ADDR, d);
        chk(d & 8'h10, 8'h10, "dac ready");
        wr(REF_CTRL_ADDR, 8'hFF);
        wr(DAC_EN_ADDR, 8'h03);
    endtask : t_bus

    initial begin
        n_mismatch = 0;
        n_checks = 0;
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        adc_enable = 1'b0;
        osc_enable = 1'b0;
        gpio_out = 2'h0;
        gpio_oe_n = 2'h3;
        gpio_pullup = 2'h0;
        t_reset(5);
        t_gpio();
        t_route();
        t_ref();
        t_bias();
        t_bus();
        t_reset(2);
        conclude();
    end

    // the sequence needs under 2000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
endmodule : aparc_top_tb_top
`default_nettype wire
